// ==== hw/pfh_pkg.sv ====
// Package: register map, field layout, reset values, types and helpers of the packet handler
package pfh_pkg;
  localparam logic [7:0] ADDR_CFG_A = 8'h30;
  localparam logic [7:0] ADDR_CFG_B = 8'h31;
  localparam logic [7:0] ADDR_LEN_LO = 8'h32;
  localparam logic [7:0] ADDR_STATION = 8'h33;
  localparam logic [7:0] ADDR_GROUP = 8'h34;
  localparam logic [7:0] ADDR_THRESH = 8'h35;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h3e;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h3f;
  localparam int FA_KIND = 7;
  localparam int FA_CODE_HI = 6;
  localparam int FA_CODE_LO = 5;
  localparam int FA_CHECK = 4;
  localparam int FA_KEEP = 3;
  localparam int FA_FILT_HI = 2;
  localparam int FA_FILT_LO = 1;
  localparam int FA_VARIANT = 0;
  localparam int FB_MODE = 6;
  localparam int FB_BEACON = 3;
  localparam int FB_LEN_HI = 2;
  localparam int FT_TRIG = 7;
  localparam int FT_MARK_HI = 5;
  localparam logic [7:0] RST_CFG_A = 8'h90;
  localparam logic [7:0] RST_CFG_B = 8'h40;
  localparam logic [7:0] RST_LEN_LO = 8'h40;
  localparam logic [7:0] RST_STATION = 8'h00;
  localparam logic [7:0] RST_GROUP = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h8f;
  localparam logic [7:0] CFG_B_RW_MASK = 8'h7f;
  localparam logic [7:0] THRESH_RW_MASK = 8'hbf;
  localparam logic [1:0] CODE_BALANCE = 2'h1;
  localparam logic [1:0] CODE_SCRAMBLE = 2'h2;
  localparam logic [1:0] FILT_ALL = 2'h0;
  localparam logic [1:0] FILT_BOTH = 2'h2;
  localparam logic [15:0] CCITT_POLY = 16'h1021;
  localparam logic [15:0] CCITT_SEED = 16'h1d0f;
  localparam logic [15:0] IBM_POLY = 16'h8005;
  localparam logic [15:0] IBM_SEED = 16'hffff;
  localparam logic [8:0] SCR_STD_SEED = 9'h1ff;
  localparam logic [8:0] SCR_ALT_SEED = 9'h1a5;
  localparam int IRQ_W = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_SENT = 3;
  localparam int IRQ_LEVEL = 4;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pfh_byte_t;
  typedef enum logic [2:0] {RX_IDLE, RX_LEN, RX_ADDR, RX_BODY, RX_CHK_HI, RX_CHK_LO} pfh_rx_st_t;
  typedef enum logic [1:0] {TX_PASS, TX_CRC_HI, TX_CRC_LO} pfh_tx_st_t;
  // One byte of MSB-first CRC
  function automatic logic [15:0] pfh_crc_byte(input logic [15:0] crc, input logic [7:0] d,
                                               input logic [15:0] poly);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ poly;
      end
    end
    return c;
  endfunction
  // Eight steps of the x^9+x^5+1 scrambler: {next state, mask byte}
  function automatic logic [16:0] pfh_scr_byte(input logic [8:0] s_in);
    logic [8:0] s;
    logic [7:0] m;
    s = s_in;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = s[0];
      s = {s[0] ^ s[5], s[8:1]};
    end
    return {s, m};
  endfunction
endpackage

// ==== hw/pfh_packet_handler.sv ====
// Packet handler: configuration registers, receive filter and check, transmit framer, interrupts
// How it works
// - Kind bit: 0 fixed, 1 variable; resets variable
// - Coding field: none, bit-balancing, scrambling; 11 reserved
// - Check enable appends/verifies CRC; resets enabled
// - Check fail: flush and restart, or keep+done
// - Address filter: all, own, own or broadcast
// - Variant bit picks CCITT/standard or IBM/alternate
// - Beacon mode only while fixed framing selected
// - Byte count 11 bits, split over two registers
// - Fixed: exact length; variable: receive maximum; 0x40
// - Own and broadcast addresses, 8 bits, reset zero
// - Send trigger: above threshold, or non-empty; resets 1
// - Level flag when count >= threshold plus one
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pfh_packet_handler
  import pfh_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  output logic IRQ_OUT,
  input wire logic [6:0] QUEUE_COUNT_IN,
  output logic QUEUE_LEVEL_OUT,
  output logic TX_GO_OUT,
  input wire logic RX_START_IN,
  input wire pfh_byte_t RX_BYTE_IN,
  output pfh_byte_t RX_PUSH_OUT,
  output logic QUEUE_FLUSH_OUT,
  output logic RX_RESTART_OUT,
  output logic PAYLOAD_DONE_OUT,
  input wire pfh_byte_t TX_BYTE_IN,
  output logic TX_READY_OUT,
  output pfh_byte_t TX_BYTE_OUT,
  output logic PACKET_SENT_OUT,
  output logic QUEUE_KEEP_OUT,
  output logic BALANCE_CODING_OUT,
  output logic PACKET_MODE_OUT
);
  logic [7:0] cfg_a_ff, cfg_b_ff, len_lo_ff, station_ff, group_ff, thresh_ff, rdata_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
  logic irq_ff, level_ff, go_ff, flush_ff, restart_ff, done_ff, sent_ff, keep_ff;
  logic balance_ff, mode_ff, tx_ready_ff, tx_fresh_ff;
  pfh_byte_t rx_push_ff, tx_out_ff;
  pfh_rx_st_t rx_st_ff, nxt_rx_st;
  pfh_tx_st_t tx_st_ff, nxt_tx_st;
  logic [10:0] rx_cnt_ff, nxt_rx_cnt, tx_left_ff, nxt_tx_left;
  logic [15:0] rx_crc_ff, nxt_rx_crc, tx_crc_ff, nxt_tx_crc;
  logic [8:0] rx_scr_ff, nxt_rx_scr, tx_scr_ff, nxt_tx_scr;
  logic [7:0] rx_hi_ff, nxt_rx_hi;
  logic nxt_push, nxt_flush, nxt_done, nxt_fail, nxt_drop;
  logic nxt_tx_valid, nxt_sent, nxt_tx_ready, nxt_tx_fresh;
  logic [7:0] nxt_tx_data;

  // Configuration decode
  wire fixed_kind = ~cfg_a_ff[FA_KIND];
  wire [1:0] coding = cfg_a_ff[FA_CODE_HI:FA_CODE_LO];
  wire scramble_on = (coding == CODE_SCRAMBLE);
  wire check_on = cfg_a_ff[FA_CHECK];
  wire keep_on = cfg_a_ff[FA_KEEP];
  wire [1:0] filt = cfg_a_ff[FA_FILT_HI:FA_FILT_LO];
  wire variant = cfg_a_ff[FA_VARIANT];
  wire [10:0] payload_max = {cfg_b_ff[FB_LEN_HI:0], len_lo_ff};
  wire beacon_on = cfg_b_ff[FB_BEACON] & fixed_kind;
  wire [5:0] mark = thresh_ff[FT_MARK_HI:0];
  wire trig_any = thresh_ff[FT_TRIG];
  wire [15:0] crc_poly = variant ? IBM_POLY : CCITT_POLY;
  wire [15:0] crc_seed = variant ? IBM_SEED : CCITT_SEED;
  wire [8:0] scr_seed = variant ? SCR_ALT_SEED : SCR_STD_SEED;

  // Register bus decode
  wire wr_cfg_a = WR_IN && (ADDR_IN == ADDR_CFG_A);
  wire wr_cfg_b = WR_IN && (ADDR_IN == ADDR_CFG_B);
  wire wr_len_lo = WR_IN && (ADDR_IN == ADDR_LEN_LO);
  wire wr_station = WR_IN && (ADDR_IN == ADDR_STATION);
  wire wr_group = WR_IN && (ADDR_IN == ADDR_GROUP);
  wire wr_thresh = WR_IN && (ADDR_IN == ADDR_THRESH);
  wire wr_stat = WR_IN && (ADDR_IN == ADDR_IRQ_STAT);
  wire wr_mask = WR_IN && (ADDR_IN == ADDR_IRQ_MASK);
  wire [IRQ_W-1:0] irq_clr = wr_stat ? WDATA_IN[IRQ_W-1:0] : '0;
  wire [7:0] rd_mux =
    (ADDR_IN == ADDR_CFG_A) ? cfg_a_ff :
    (ADDR_IN == ADDR_CFG_B) ? cfg_b_ff :
    (ADDR_IN == ADDR_LEN_LO) ? len_lo_ff :
    (ADDR_IN == ADDR_STATION) ? station_ff :
    (ADDR_IN == ADDR_GROUP) ? group_ff :
    (ADDR_IN == ADDR_THRESH) ? thresh_ff :
    (ADDR_IN == ADDR_IRQ_STAT) ? {3'h0, irq_stat_ff} :
    (ADDR_IN == ADDR_IRQ_MASK) ? {3'h0, irq_mask_ff} : 8'h00;

  // Queue level and send trigger
  wire level_now = (QUEUE_COUNT_IN >= ({1'b0, mark} + 7'h01));
  wire go_now = trig_any ? (QUEUE_COUNT_IN != 7'h00) : level_now;

  // Receive datapath
  wire rx_take = RX_BYTE_IN.valid && (rx_st_ff != RX_IDLE);
  wire [16:0] rx_scr_w = pfh_scr_byte(rx_scr_ff);
  wire [7:0] rx_plain = RX_BYTE_IN.data ^ (scramble_on ? rx_scr_w[7:0] : 8'h00);
  wire [15:0] rx_crc_w = pfh_crc_byte(rx_crc_ff, rx_plain, crc_poly);
  wire [15:0] rx_fin = variant ? rx_crc_ff : ~rx_crc_ff;
  wire rx_chk_ok = ({rx_hi_ff, rx_plain} == rx_fin);
  wire addr_ok = (filt == FILT_ALL) || (rx_plain == station_ff) ||
                 ((filt == FILT_BOTH) && (rx_plain == group_ff));
  wire len_bad = ({3'h0, rx_plain} > payload_max) || (rx_plain == 8'h00);
  wire rx_last = (rx_cnt_ff == 11'h001);
  wire rx_fail_now = rx_take && (rx_st_ff == RX_CHK_LO) && !rx_chk_ok;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_crc = rx_crc_ff;
    nxt_rx_scr = rx_scr_ff;
    nxt_rx_hi = rx_hi_ff;
    nxt_push = 1'b0;
    nxt_flush = 1'b0;
    nxt_done = 1'b0;
    nxt_fail = 1'b0;
    nxt_drop = 1'b0;
    if (RX_START_IN) begin
      nxt_rx_crc = crc_seed;
      nxt_rx_scr = scr_seed;
      nxt_rx_cnt = payload_max;
      if (!fixed_kind) begin
        nxt_rx_st = RX_LEN;
      end else if (filt != FILT_ALL) begin
        nxt_rx_st = RX_ADDR;
      end else begin
        nxt_rx_st = RX_BODY;
      end
    end else if (rx_take) begin
      nxt_rx_scr = rx_scr_w[16:8];
      case (rx_st_ff)
        RX_LEN: begin
          nxt_rx_crc = rx_crc_w;
          nxt_push = 1'b1;
          nxt_rx_cnt = {3'h0, rx_plain};
          if (len_bad) begin
            nxt_drop = 1'b1;
            nxt_rx_st = RX_IDLE;
          end else begin
            nxt_rx_st = (filt != FILT_ALL) ? RX_ADDR : RX_BODY;
          end
        end
        RX_ADDR, RX_BODY: begin
          nxt_rx_crc = rx_crc_w;
          nxt_push = 1'b1;
          nxt_rx_cnt = rx_cnt_ff - 11'h001;
          if ((rx_st_ff == RX_ADDR) && !addr_ok) begin
            nxt_drop = 1'b1;
            nxt_rx_st = RX_IDLE;
          end else if (rx_last) begin
            nxt_rx_st = check_on ? RX_CHK_HI : RX_IDLE;
            nxt_done = !check_on;
          end else begin
            nxt_rx_st = RX_BODY;
          end
        end
        RX_CHK_HI: begin
          nxt_rx_hi = rx_plain;
          nxt_rx_st = RX_CHK_LO;
        end
        RX_CHK_LO: begin
          nxt_rx_st = RX_IDLE;
          nxt_fail = !rx_chk_ok;
          nxt_done = rx_chk_ok || keep_on;
          nxt_drop = !rx_chk_ok && !keep_on;
        end
        default: begin
          nxt_rx_st = RX_IDLE;
        end
      endcase
    end
    nxt_flush = nxt_drop;
  end

  // Transmit datapath
  wire tx_take = TX_BYTE_IN.valid && tx_ready_ff;
  wire [15:0] tx_base_crc = tx_fresh_ff ? crc_seed : tx_crc_ff;
  wire [16:0] tx_scr_w = pfh_scr_byte(tx_fresh_ff ? scr_seed : tx_scr_ff);
  wire [7:0] tx_mask = scramble_on ? tx_scr_w[7:0] : 8'h00;
  wire [15:0] tx_fin = variant ? tx_crc_ff : ~tx_crc_ff;
  wire tx_final = tx_fresh_ff ?
                  (fixed_kind ? (payload_max == 11'h001) : (TX_BYTE_IN.data == 8'h00)) :
                  (tx_left_ff == 11'h001);

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_crc = tx_crc_ff;
    nxt_tx_scr = tx_scr_ff;
    nxt_tx_valid = 1'b0;
    nxt_tx_data = tx_out_ff.data;
    nxt_sent = 1'b0;
    nxt_tx_ready = tx_ready_ff;
    nxt_tx_fresh = tx_fresh_ff;
    case (tx_st_ff)
      TX_PASS: begin
        if (tx_take) begin
          nxt_tx_valid = 1'b1;
          nxt_tx_data = TX_BYTE_IN.data ^ tx_mask;
          nxt_tx_crc = pfh_crc_byte(tx_base_crc, TX_BYTE_IN.data, crc_poly);
          nxt_tx_scr = tx_scr_w[16:8];
          nxt_tx_fresh = 1'b0;
          if (tx_fresh_ff) begin
            nxt_tx_left = fixed_kind ? (payload_max - 11'h001) : {3'h0, TX_BYTE_IN.data};
          end else begin
            nxt_tx_left = tx_left_ff - 11'h001;
          end
          if (tx_final) begin
            if (check_on) begin
              nxt_tx_st = TX_CRC_HI;
              nxt_tx_ready = 1'b0;
            end else begin
              nxt_sent = 1'b1;
              nxt_tx_fresh = 1'b1;
            end
          end
        end
      end
      TX_CRC_HI: begin
        nxt_tx_valid = 1'b1;
        nxt_tx_data = tx_fin[15:8] ^ tx_mask;
        nxt_tx_scr = tx_scr_w[16:8];
        nxt_tx_st = TX_CRC_LO;
      end
      TX_CRC_LO: begin
        nxt_tx_valid = 1'b1;
        nxt_tx_data = tx_fin[7:0] ^ tx_mask;
        nxt_sent = 1'b1;
        nxt_tx_fresh = 1'b1;
        nxt_tx_ready = 1'b1;
        nxt_tx_st = TX_PASS;
      end
      default: begin
        nxt_tx_st = TX_PASS;
        nxt_tx_ready = 1'b1;
      end
    endcase
  end

  wire level_rise = level_now && !level_ff;
  assign irq_set = {level_rise, nxt_sent, nxt_drop, nxt_fail, nxt_done};

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_a_ff <= RST_CFG_A;
      cfg_b_ff <= RST_CFG_B;
      len_lo_ff <= RST_LEN_LO;
      station_ff <= RST_STATION;
      group_ff <= RST_GROUP;
      thresh_ff <= RST_THRESH;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else if (CE_IN) begin
      if (wr_cfg_a) cfg_a_ff <= WDATA_IN;
      if (wr_cfg_b) cfg_b_ff <= WDATA_IN & CFG_B_RW_MASK;
      if (wr_len_lo) len_lo_ff <= WDATA_IN;
      if (wr_station) station_ff <= WDATA_IN;
      if (wr_group) group_ff <= WDATA_IN;
      if (wr_thresh) thresh_ff <= WDATA_IN & THRESH_RW_MASK;
      if (wr_mask) irq_mask_ff <= WDATA_IN[IRQ_W-1:0];
      // Set wins over a same-cycle write-one clear
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      rdata_ff <= RD_IN ? rd_mux : 8'h00;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 11'h000;
      rx_crc_ff <= 16'h0000;
      rx_scr_ff <= 9'h000;
      rx_hi_ff <= 8'h00;
      rx_push_ff <= '0;
      flush_ff <= 1'b0;
      restart_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (CE_IN) begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_crc_ff <= nxt_rx_crc;
      rx_scr_ff <= nxt_rx_scr;
      rx_hi_ff <= nxt_rx_hi;
      rx_push_ff <= '{valid: nxt_push, data: rx_plain};
      flush_ff <= nxt_flush;
      restart_ff <= nxt_flush;
      done_ff <= nxt_done;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_st_ff <= TX_PASS;
      tx_left_ff <= 11'h000;
      tx_crc_ff <= 16'h0000;
      tx_scr_ff <= 9'h000;
      tx_out_ff <= '0;
      tx_ready_ff <= 1'b1;
      tx_fresh_ff <= 1'b1;
      sent_ff <= 1'b0;
      level_ff <= 1'b0;
      go_ff <= 1'b0;
      keep_ff <= 1'b0;
      balance_ff <= 1'b0;
      mode_ff <= 1'b1;
    end else if (CE_IN) begin
      tx_st_ff <= nxt_tx_st;
      tx_left_ff <= nxt_tx_left;
      tx_crc_ff <= nxt_tx_crc;
      tx_scr_ff <= nxt_tx_scr;
      tx_out_ff <= '{valid: nxt_tx_valid, data: nxt_tx_data};
      tx_ready_ff <= nxt_tx_ready;
      tx_fresh_ff <= nxt_tx_fresh;
      sent_ff <= nxt_sent;
      level_ff <= level_now;
      go_ff <= go_now;
      keep_ff <= beacon_on;
      balance_ff <= (coding == CODE_BALANCE);
      mode_ff <= cfg_b_ff[FB_MODE];
    end
  end

  assign RDATA_OUT = rdata_ff;
  assign IRQ_OUT = irq_ff;
  assign QUEUE_LEVEL_OUT = level_ff;
  assign TX_GO_OUT = go_ff;
  assign RX_PUSH_OUT = rx_push_ff;
  assign QUEUE_FLUSH_OUT = flush_ff;
  assign RX_RESTART_OUT = restart_ff;
  assign PAYLOAD_DONE_OUT = done_ff;
  assign TX_READY_OUT = tx_ready_ff;
  assign TX_BYTE_OUT = tx_out_ff;
  assign PACKET_SENT_OUT = sent_ff;
  assign QUEUE_KEEP_OUT = keep_ff;
  assign BALANCE_CODING_OUT = balance_ff;
  assign PACKET_MODE_OUT = mode_ff;

  // A frozen clock enable cancels pending checks rather than stretching them
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN || !CE_IN);

  go_trigger_a: assert property (trig_any && (QUEUE_COUNT_IN != 7'h00) |=> TX_GO_OUT)
    else $error("send trigger missed on non-empty queue");
  level_mark_a: assert property (QUEUE_COUNT_IN == {1'b0, mark} |=> !QUEUE_LEVEL_OUT)
    else $error("level flag set at threshold count");
  len_drop_a: assert property (rx_take && (rx_st_ff == RX_LEN) && len_bad && !RX_START_IN
    |=> QUEUE_FLUSH_OUT && RX_RESTART_OUT && !PAYLOAD_DONE_OUT)
    else $error("oversize frame not dropped");
  fail_flush_a: assert property (rx_fail_now && !keep_on && !RX_START_IN
    |=> QUEUE_FLUSH_OUT && !PAYLOAD_DONE_OUT ##1 irq_stat_ff[IRQ_FAIL])
    else $error("check fail did not flush");
  fail_keep_a: assert property (rx_fail_now && keep_on && !RX_START_IN
    |=> PAYLOAD_DONE_OUT && !QUEUE_FLUSH_OUT)
    else $error("check fail with keep did not finish");
  addr_own_a: assert property (rx_take && (rx_st_ff == RX_ADDR) && (filt == 2'h1) &&
    (rx_plain != station_ff) && !RX_START_IN |=> QUEUE_FLUSH_OUT)
    else $error("foreign address accepted");
  nocheck_done_a: assert property (rx_take && (rx_st_ff == RX_BODY) && rx_last && !check_on &&
    !RX_START_IN |=> PAYLOAD_DONE_OUT && (rx_st_ff == RX_IDLE))
    else $error("frame without check not finished");
  tx_append_a: assert property (tx_take && tx_final && check_on
    |=> !TX_READY_OUT [*2] ##1 TX_READY_OUT && PACKET_SENT_OUT)
    else $error("check bytes not appended");
  beacon_fixed_a: assert property (QUEUE_KEEP_OUT |-> $past(fixed_kind))
    else $error("beacon active in variable framing");
  irq_gate_a: assert property (|(irq_stat_ff & irq_mask_ff) |=> IRQ_OUT)
    else $error("unmasked event did not raise interrupt");

  done_seen_c: cover property (rx_take && (rx_st_ff == RX_CHK_LO) && rx_chk_ok ##1 PAYLOAD_DONE_OUT);
  drop_seen_c: cover property (rx_take && (rx_st_ff == RX_LEN) && len_bad);
  sent_seen_c: cover property (PACKET_SENT_OUT && check_on);
  fail_seen_c: cover property (rx_fail_now);
endmodule
`default_nettype wire

// ==== tb/pfh_host_model.sv ====
// Host-side FIFO model: keeps pushed bytes and feeds them back for transmit
`timescale 1ns/1ps
`default_nettype none
module pfh_host_model
  import pfh_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic send_en_in,
  input wire pfh_byte_t push_in,
  input wire logic flush_in,
  input wire logic ready_in,
  output pfh_byte_t tx_byte_out,
  output logic [6:0] count_out
);
  logic [7:0] q[$];
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q.delete();
      tx_byte_out <= '0;
      count_out <= 7'h00;
    end else begin
      // Flush wins over a push in the same cycle
      if (flush_in) begin
        q.delete();
      end else begin
        if (tx_byte_out.valid && ready_in) begin
          void'(q.pop_front());
        end
        if (push_in.valid) begin
          q.push_back(push_in.data);
        end
      end
      // Idle data toggles so a stale byte never passes for a fresh one
      if (send_en_in && q.size() > 0) begin
        tx_byte_out <= '{valid: 1'b1, data: q[0]};
      end else begin
        tx_byte_out <= '{valid: 1'b0, data: ~tx_byte_out.data};
      end
      count_out <= 7'(q.size());
    end
  end
endmodule
`default_nettype wire

// ==== tb/fsk_packet_handler_config_tb.sv ====
// Self-checking bench: registers, receive filter and check, transmit, interrupts
`timescale 1ns/1ps
`default_nettype none
module fsk_packet_handler_config_tb
  import pfh_pkg::*;
;
  typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} pfh_reg_row_t;
  typedef struct {logic [7:0] cfg; int n; logic [23:0] b; int ck; int ed; int ef;} pfh_rx_row_t;
  logic clk, rst, wr_s, rd_s, rx_start, send_en, irq, level, go, flush, restart, done;
  logic ready, sent, keep, bal, mode, ce;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] count;
  pfh_byte_t rx_byte, push, tx_in, tx_out;
  int fail_count, n_compared, n_done, n_flush, n_rst, n_sent;
  logic [7:0] txq[$];
  pfh_reg_row_t reg_rows [15] = '{'{8'h30, 0, 0, 8'h90}, '{8'h31, 0, 0, 8'h40},
    '{8'h32, 0, 0, 8'h40}, '{8'h33, 0, 0, 8'h00}, '{8'h34, 0, 0, 8'h00}, '{8'h35, 0, 0, 8'h8f},
    '{8'h3e, 0, 0, 8'h00}, '{8'h3f, 0, 0, 8'h00}, '{8'h36, 1, 8'hff, 8'h00},
    '{8'h31, 1, 8'hff, 8'h7f}, '{8'h31, 1, 8'h40, 8'h40}, '{8'h35, 1, 8'hff, 8'hbf},
    '{8'h33, 1, 8'ha5, 8'ha5}, '{8'h34, 1, 8'h3c, 8'h3c}, '{8'h32, 1, 8'h03, 8'h03}};
  // Fixed frames are three bytes; variable maximum is three
  pfh_rx_row_t rx_rows [12] = '{'{8'h02, 3, 24'h117788, 0, 0, 1},
    '{8'h02, 3, 24'ha57788, 0, 1, 0}, '{8'h04, 3, 24'h3c7788, 0, 1, 0},
    '{8'h02, 3, 24'h3c7788, 0, 0, 1}, '{8'h10, 3, 24'h123456, 1, 1, 0},
    '{8'h10, 3, 24'h123456, 2, 0, 1}, '{8'h18, 3, 24'h123456, 2, 1, 0},
    '{8'h11, 3, 24'h123456, 3, 1, 0}, '{8'h50, 3, 24'h123456, 1, 1, 0},
    '{8'h51, 3, 24'h9a0b7c, 3, 1, 0}, '{8'h80, 1, 24'h050000, 0, 0, 1},
    '{8'h80, 3, 24'h02aabb, 0, 1, 0}};
  pfh_packet_handler i_dut (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .IRQ_OUT(irq),
    .QUEUE_COUNT_IN(count), .QUEUE_LEVEL_OUT(level), .TX_GO_OUT(go), .RX_START_IN(rx_start),
    .RX_BYTE_IN(rx_byte), .RX_PUSH_OUT(push), .QUEUE_FLUSH_OUT(flush),
    .RX_RESTART_OUT(restart), .PAYLOAD_DONE_OUT(done), .TX_BYTE_IN(tx_in),
    .TX_READY_OUT(ready), .TX_BYTE_OUT(tx_out), .PACKET_SENT_OUT(sent),
    .QUEUE_KEEP_OUT(keep), .BALANCE_CODING_OUT(bal), .PACKET_MODE_OUT(mode));
  pfh_host_model i_host (.mclk_in(clk), .rst_in(rst), .send_en_in(send_en), .push_in(push),
    .flush_in(flush), .ready_in(ready), .tx_byte_out(tx_in), .count_out(count));
  always @(posedge clk) begin
    if (done === 1'b1) n_done++;
    if (flush === 1'b1) n_flush++;
    if (restart === 1'b1) n_rst++;
    if (sent === 1'b1) n_sent++;
    if (tx_out.valid === 1'b1) txq.push_back(tx_out.data);
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  // CRC of the first n bytes of b, MSB first; CCITT result inverted
  function automatic logic [15:0] crc3(input logic [23:0] b, input int n, input logic ibm);
    logic [15:0] c;
    logic fb;
    c = ibm ? IBM_SEED : CCITT_SEED;
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        fb = c[15] ^ b[16 - 8 * i + j];
        c = {c[14:0], 1'b0} ^ (fb ? (ibm ? IBM_POLY : CCITT_POLY) : 16'h0000);
      end
    end
    return ibm ? c : ~c;
  endfunction
  // Scrambler mask of frame byte k: x^9+x^5+1, first bit into the LSB
  function automatic logic [7:0] wmask(input int k, input logic alt);
    logic [8:0] s;
    logic [7:0] m;
    s = alt ? SCR_ALT_SEED : SCR_STD_SEED;
    m = 8'h00;
    for (int i = 0; i <= 8 * k + 7; i++) begin
      m = {s[0], m[7:1]};
      s = {s[0] ^ s[5], s[8:1]};
    end
    return m;
  endfunction
  task automatic send_frame(input pfh_rx_row_t r);
    logic [7:0] fr [0:4];
    logic [15:0] c;
    int m;
    fr = '{r.b[23:16], r.b[15:8], r.b[7:0], 8'h00, 8'h00};
    m = r.n;
    if (r.ck != 0) begin
      c = crc3(r.b, r.n, r.ck == 3) ^ ((r.ck == 2) ? 16'h0001 : 16'h0000);
      fr[r.n] = c[15:8];
      fr[r.n + 1] = c[7:0];
      m = r.n + 2;
    end
    // Scrambling spans payload and check bytes
    for (int i = 0; i < m; i++) begin
      if (r.cfg[FA_CODE_HI:FA_CODE_LO] == CODE_SCRAMBLE) fr[i] = fr[i] ^ wmask(i, r.cfg[FA_VARIANT]);
    end
    wr(ADDR_CFG_A, r.cfg);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    for (int i = 0; i < m; i++) begin
      rx_byte <= '{valid: 1'b1, data: fr[i]};
      @(posedge clk);
    end
    rx_byte <= '{valid: 1'b0, data: 8'h00};
    repeat (3) @(posedge clk);
  endtask
  // Loop the host queue back out and compare what leaves the framer
  task automatic send_tx(input logic [39:0] ex, input int n);
    int s;
    int k;
    txq.delete();
    s = n_sent;
    send_en <= 1'b1;
    for (k = 0; k < 100 && n_sent == s; k++) @(posedge clk);
    send_en <= 1'b0;
    if (n_sent == s) begin
      fail_count++;
      summarize();
    end
    repeat (2) @(posedge clk);
    chk(8'(txq.size()), 8'(n));
    for (int i = 0; i < n && i < txq.size(); i++) chk(txq[i], ex[39 - 8 * i -: 8]);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    logic [7:0] v;
    logic [15:0] c;
    int d0;
    int f0;
    int r0;
    rst = 1'b1;
    {addr, wdata, wr_s, rd_s, rx_start, send_en} = '0;
    ce = 1'b1;
    rx_byte = '0;
    {fail_count, n_compared, n_done, n_flush, n_rst, n_sent} = '0;
    repeat (12) @(posedge clk);
    chk({6'h00, ready, mode}, 8'h03);
    chk({keep, bal, irq, level, go, done, flush, sent}, 8'h00);
    rst <= 1'b0;
    @(posedge clk);
    foreach (reg_rows[i]) begin
      if (reg_rows[i].w) wr(reg_rows[i].a, reg_rows[i].d);
      rd(reg_rows[i].a, v);
      chk(v, reg_rows[i].e);
    end
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(ADDR_STATION, 8'h11);
    ce <= 1'b1;
    rd(ADDR_STATION, v);
    chk(v, 8'ha5);
    foreach (rx_rows[i]) begin
      d0 = n_done;
      f0 = n_flush;
      r0 = n_rst;
      send_frame(rx_rows[i]);
      chk(8'(n_done - d0), 8'(rx_rows[i].ed));
      chk(8'(n_flush - f0), 8'(rx_rows[i].ef));
      chk(8'(n_rst - r0), 8'(rx_rows[i].ef));
    end
    chk({1'b0, count}, 8'h03);
    wr(ADDR_CFG_A, 8'h90);
    c = crc3(24'h02aabb, 3, 1'b0);
    send_tx({24'h02aabb, c}, 5);
    send_frame('{8'h00, 3, 24'ha1b2c3, 0, 1, 0});
    wr(ADDR_IRQ_MASK, 8'h10);
    wr(ADDR_THRESH, 8'h03);
    repeat (3) @(posedge clk);
    chk({5'h00, irq, level, go}, 8'h00);
    wr(ADDR_THRESH, 8'h02);
    repeat (3) @(posedge clk);
    chk({5'h00, irq, level, go}, 8'h07);
    rd(ADDR_IRQ_STAT, v);
    chk(v, 8'h1f);
    wr(ADDR_IRQ_STAT, 8'hff);
    repeat (2) @(posedge clk);
    rd(ADDR_IRQ_STAT, v);
    chk({v[6:0], irq}, 8'h00);
    send_tx({24'ha1b2c3, 16'h0000}, 3);
    wr(ADDR_CFG_B, 8'h08);
    repeat (2) @(posedge clk);
    chk({5'h00, keep, bal, mode}, 8'h04);
    wr(ADDR_CFG_A, 8'ha0);
    repeat (2) @(posedge clk);
    chk({5'h00, keep, bal, mode}, 8'h02);
    // Scrambled fixed frame in, plain bytes queued, scrambled bytes out
    send_frame('{8'h40, 3, 24'ha1b2c3, 0, 1, 0});
    send_tx({8'ha1 ^ wmask(0, 1'b0), 8'hb2 ^ wmask(1, 1'b0), 8'hc3 ^ wmask(2, 1'b0),
      16'h0000}, 3);
    summarize();
  end
endmodule
`default_nettype wire
